/* core/ics_pkg.sv */
/*
  Shared constants and types of the serial command port: bus address,
  command entry byte layout, frame limit, host register map and timing.
  Assumes a 125 MHz pclk on both ends.
*/
package ics_pkg;
  // Bus address bytes of the target
  localparam logic [7:0] DEV_ADDR_W = 8'he2;
  localparam logic [7:0] DEV_ADDR_R = 8'he3;
  // Command entry byte fields
  localparam int CMD_DONLY_BIT = 7;
  localparam int CMD_TGT_LSB   = 5;
  localparam int CMD_DIR_BIT   = 3;
  localparam int CMD_DLEN_LSB  = 1;
  localparam int CMD_ALEN_BIT  = 0;
  // Documented command entry bytes
  localparam logic [7:0] INSTR_MEM_WRITE_CMD = 8'h0d;
  localparam logic [7:0] INSTR_MEM_READ_CMD  = 8'h07;
  localparam logic [7:0] DATA_MEM_WRITE_CMD  = 8'h2b;
  localparam logic [7:0] DATA_MEM_READ_CMD   = 8'h27;
  localparam logic [7:0] REG_WRITE1_CMD      = 8'h48;
  localparam logic [7:0] REG_WRITE2_CMD      = 8'h4a;
  localparam logic [7:0] REG_READ_CMD        = 8'h46;
  localparam logic [1:0]  ALEN_LONG       = 2'h3;
  localparam logic [1:0]  ALEN_SHORT      = 2'h1;
  localparam logic [16:0] FRAME_MAX_BYTES = 17'h10000;
  localparam logic [23:0] BCNT_REG_ADDR   = 24'h000008;
  localparam logic [3:0]  LAST_BIT        = 4'h7;
  localparam logic [3:0]  BYTE_BITS       = 4'h8;
  // Host timing: four quarters per bit, least quarter rounded up
  localparam int CLK_HZ      = 125000000;
  localparam int BUS_RATE_HZ = 400000;
  localparam int QTR_CYCLES  = (CLK_HZ + 4 * BUS_RATE_HZ - 1) / (4 * BUS_RATE_HZ);
  localparam int QTR_W       = 7;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYCLES - 1);
  // Host APB register map
  localparam logic [11:0] HREG_CMD  = 12'h000;
  localparam logic [11:0] HREG_DATA = 12'h004;
  localparam logic [11:0] HREG_STAT = 12'h008;
  localparam int CMD_ACK_BIT  = 2;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_NACK    = 1;

  typedef enum logic [1:0] {
    TGT_INSTR = 2'h0, TGT_DATA = 2'h1, TGT_REG = 2'h2, TGT_RSVD = 2'h3
  } ics_tgt_t;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_RX = 3'h1, DS_ACK = 3'h3, DS_TX = 3'h2, DS_RACK = 3'h6, DS_SKIP = 3'h7
  } ics_dst_t;
  typedef enum logic [1:0] {PH_CMD = 2'h0, PH_ADDR = 2'h1, PH_DATA = 2'h3} ics_ph_t;
  typedef enum logic [1:0] {HS_IDLE = 2'h0, HS_START = 2'h1, HS_BIT = 2'h3, HS_STOP = 2'h2} ics_hst_t;
  typedef enum logic [1:0] {OP_STOP = 2'h0, OP_START = 2'h1, OP_WRITE = 2'h2, OP_READ = 2'h3} ics_op_t;

  typedef struct packed {
    logic [1:0]  tgt;
    logic        wr;
    logic [23:0] addr;
    logic [31:0] data;
    logic [2:0]  nbytes;
  } ics_req_t;

  function automatic logic [2:0] ics_dlen(input logic [1:0] f);
    case (f)
      2'h0:    ics_dlen = 3'h1;
      2'h1:    ics_dlen = 3'h2;
      2'h2:    ics_dlen = 3'h4;
      default: ics_dlen = 3'h0;
    endcase
  endfunction
endpackage

/* core/ics_if.sv */
/*
  Two-wire link between the host end and the device end.
  Assumes open-drain pins with a pull-up; enables are active low.
*/
`timescale 1ns/1ps
`default_nettype none
interface ics_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // Wired-AND with pull-up
  assign scl = !(!host_scl_oe_n && !host_scl_o);
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

  modport host (output host_scl_o, output host_scl_oe_n, output host_sda_o,
                output host_sda_oe_n, input scl, input sda);
  modport dev  (output dev_sda_o, output dev_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

/* core/ics_dev_end.sv */
/*
  Device end of the serial command port: bus target that decodes command
  sequences into memory and register requests, through a two-entry buffer.
  Assumes the host keeps to the bus framing; pins arrive asynchronously.
*/
// Implementation choices: the register addresses and register access over APB.
// Overview of operation
// - Works at bus rates up to 400 Kbps
// - Answers bus address byte 0xE2 for writes
// - Eight data bits, then one acknowledge bit
// - Acknowledge accepted bytes, otherwise leave not-acknowledge
// - Stop anywhere abandons the transfer in progress
// - Host opens with start, closes with stop
// - Start/stop: data edge while clock high
// - Many sequences per frame, 64K bytes max
// - First byte of sequence is command entry
// - Instruction memory write 0x0D, read 0x07
// - Data memory write 0x2B, read 0x27
// - Register write 0x48, 0x4A; read 0x46
// - Top bit set: data only until count zero
// - Bits 6-5 pick target; 11 reserved
// - Bit 3 clear means read
// - Bits 2-1 give data byte count
// - Bit 0 gives one or three address bytes
`timescale 1ns/1ps
`default_nettype none
module ics_dev_end
  import ics_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  ics_if.dev               bus,
  output logic             req_valid,
  input  wire logic        req_ready,
  output ics_req_t         req,
  input  wire logic [31:0] rd_data
);

  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_f;
    logic        sda_f;
    ics_dst_t    st;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic        first;
    logic        rd;
    logic        ack;
    ics_ph_t     ph;
    logic [7:0]  cmd;
    logic [1:0]  acnt;
    logic [1:0]  aidx;
    logic [2:0]  dcnt;
    logic [1:0]  didx;
    logic [23:0] addr;
    logic [31:0] data;
    logic        donly;
    logic [15:0] bleft;
    logic [15:0] bcnt;
    logic [16:0] fcnt;
    logic [1:0]  tidx;
    logic        sda_oe_n;
    logic        v0;
    logic        v1;
    ics_req_t    q0;
    ics_req_t    q1;
  } ics_dstate_t;

  localparam ics_dstate_t D_RST = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                                    st: DS_IDLE, ph: PH_CMD, sda_oe_n: 1'b1, default: '0};

  ics_dstate_t s;
  ics_dstate_t n;

  function automatic logic [7:0] rbyte(input logic [31:0] w, input logic [1:0] i);
    rbyte = w[8*i +: 8];
  endfunction

  function automatic ics_req_t mkreq(input logic [7:0] c, input logic [23:0] a,
                                     input logic [31:0] d, input logic [2:0] nb);
    mkreq = '{tgt: c[CMD_TGT_LSB +: 2], wr: c[CMD_DIR_BIT], addr: a, data: d, nbytes: nb};
  endfunction

  always_comb begin
    ics_req_t pr;
    logic ok, push, rise, fall, start, stop;
    logic [7:0] b;
    logic [31:0] wd;
    pr = '0;
    ok = 1'b1;
    push = 1'b0;
    b = '0;
    wd = '0;
    n = s;
    n.scl_s = {s.scl_s[1:0], bus.scl};
    n.sda_s = {s.sda_s[1:0], bus.sda};
    // Glitch filter: second and third stages must agree
    if (s.scl_s[1] == s.scl_s[2]) n.scl_f = s.scl_s[2];
    if (s.sda_s[1] == s.sda_s[2]) n.sda_f = s.sda_s[2];
    rise  = n.scl_f & ~s.scl_f;
    fall  = ~n.scl_f & s.scl_f;
    start = n.scl_f & s.scl_f & s.sda_f & ~n.sda_f;
    stop  = n.scl_f & s.scl_f & ~s.sda_f & n.sda_f;
    if (s.v0 && req_ready) begin
      n.v0 = s.v1;
      n.q0 = s.q1;
      n.v1 = 1'b0;
    end
    if (stop) begin
      // Partial sequences are dropped; data-only mode survives frames
      n.st = DS_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (start) begin
      n.st = DS_RX;
      n.bitc = '0;
      n.first = 1'b1;
      n.fcnt = '0;
      n.ph = PH_CMD;
      n.tidx = '0;
      n.sda_oe_n = 1'b1;
    end else begin
      case (s.st)
        DS_RX: begin
          if (rise) begin
            b = {s.sh[6:0], n.sda_f};
            n.sh = b;
            n.bitc = s.bitc + 4'h1;
            if (s.bitc == LAST_BIT) begin
              n.fcnt = s.fcnt + 17'h1;
              if (s.fcnt == FRAME_MAX_BYTES) begin
                ok = 1'b0;
              end else if (s.first) begin
                n.first = 1'b0;
                n.rd = (b == DEV_ADDR_R);
                ok = (b == DEV_ADDR_W) || (b == DEV_ADDR_R);
              end else if (s.donly) begin
                pr = mkreq(s.cmd, s.addr, {24'h0, b}, 3'h1);
                push = 1'b1;
                ok = ~s.v1;
                if (ok) begin
                  n.addr = s.addr + 24'h1;
                  n.bleft = s.bleft - 16'h1;
                  n.donly = (s.bleft != 16'h1);
                end
              end else begin
                case (s.ph)
                  PH_CMD: begin
                    n.cmd = b;
                    ok = (b[CMD_TGT_LSB +: 2] != TGT_RSVD);
                    n.addr = '0;
                    n.data = '0;
                    n.aidx = '0;
                    n.didx = '0;
                    n.acnt = b[CMD_ALEN_BIT] ? ALEN_LONG : ALEN_SHORT;
                    n.dcnt = ics_dlen(b[CMD_DLEN_LSB +: 2]);
                    if (b[CMD_DONLY_BIT]) begin
                      n.donly = (s.bcnt != '0);
                      n.bleft = s.bcnt;
                    end else if (ok) begin
                      n.ph = PH_ADDR;
                    end
                  end
                  PH_ADDR: begin
                    n.addr[8*s.aidx +: 8] = b;
                    n.aidx = s.aidx + 2'h1;
                    n.acnt = s.acnt - 2'h1;
                    if (s.acnt == ALEN_SHORT) begin
                      if (s.dcnt == '0) begin
                        // No data bytes follow, so the request goes out now; bit 3 sets its direction
                        pr = mkreq(s.cmd, n.addr, '0, '0);
                        push = 1'b1;
                        ok = ~s.v1;
                        n.ph = PH_CMD;
                      end else begin
                        n.ph = PH_DATA;
                      end
                    end
                  end
                  default: begin
                    wd = s.data;
                    wd[8*s.didx +: 8] = b;
                    n.data = wd;
                    n.didx = s.didx + 2'h1;
                    n.dcnt = s.dcnt - 3'h1;
                    if (s.dcnt == 3'h1) begin
                      pr = mkreq(s.cmd, s.addr, wd, ics_dlen(s.cmd[CMD_DLEN_LSB +: 2]));
                      push = 1'b1;
                      ok = ~s.v1;
                      n.ph = PH_CMD;
                      if (ok && s.cmd[CMD_TGT_LSB +: 2] == TGT_REG && s.addr == BCNT_REG_ADDR)
                        n.bcnt = wd[15:0];
                    end
                  end
                endcase
              end
              n.ack = ok;
            end
          end else if (fall && s.bitc == BYTE_BITS) begin
            n.st = DS_ACK;
            n.sda_oe_n = ~s.ack;
          end
        end
        DS_ACK: begin
          if (fall) begin
            n.sda_oe_n = 1'b1;
            n.bitc = '0;
            if (!s.ack) begin
              // Refused byte: ignore the rest of the frame
              n.st = DS_SKIP;
            end else if (s.rd) begin
              n.st = DS_TX;
              n.sh = rbyte(rd_data, s.tidx);
              n.sda_oe_n = n.sh[7];
            end else begin
              n.st = DS_RX;
            end
          end
        end
        DS_TX: begin
          if (rise) begin
            n.bitc = s.bitc + 4'h1;
          end else if (fall) begin
            if (s.bitc == BYTE_BITS) begin
              n.sda_oe_n = 1'b1;
              n.st = DS_RACK;
            end else begin
              n.sh = {s.sh[6:0], 1'b0};
              n.sda_oe_n = s.sh[6];
            end
          end
        end
        DS_RACK: begin
          if (rise) begin
            n.ack = ~n.sda_f;
          end else if (fall) begin
            if (s.ack) begin
              n.tidx = s.tidx + 2'h1;
              n.sh = rbyte(rd_data, n.tidx);
              n.sda_oe_n = n.sh[7];
              n.bitc = '0;
              n.st = DS_TX;
              if (s.donly && !s.cmd[CMD_DIR_BIT]) begin
                n.bleft = s.bleft - 16'h1;
                n.donly = (s.bleft != 16'h1);
              end
            end else begin
              n.st = DS_SKIP;
            end
          end
        end
        default: ;
      endcase
    end
    // A full buffer answers with not-acknowledge instead of losing a word
    if (push && ok) begin
      if (n.v0) begin
        n.v1 = 1'b1;
        n.q1 = pr;
      end else begin
        n.v0 = 1'b1;
        n.q0 = pr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= D_RST;
    end else begin
      s <= n;
    end
  end

  assign req_valid = s.v0;
  assign req = s.q0;
  assign bus.dev_sda_oe_n = s.sda_oe_n;
  assign bus.dev_sda_o = 1'b0;

endmodule
`default_nettype wire

/* core/ics_host_end.sv */
/*
  Host end of the serial command port: bus controller driven by software
  over APB through a command, data and status register.
  Assumes one transaction at a time; no clock stretching by the target.
*/
`timescale 1ns/1ps
`default_nettype none
module ics_host_end
  import ics_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  ics_if.host              bus,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef struct packed {
    logic [2:0]       sda_s;
    logic             sda_f;
    ics_hst_t         st;
    logic [QTR_W-1:0] qcnt;
    logic [1:0]       ph;
    logic [3:0]       bitn;
    logic             rdop;
    logic             ackv;
    logic [7:0]       tx;
    logic [7:0]       rx;
    logic             nack;
    logic             scl_oe_n;
    logic             sda_oe_n;
    logic             pready;
    logic [31:0]      prdata;
  } ics_hstate_t;

  localparam ics_hstate_t H_RST = '{sda_s: 3'h7, sda_f: 1'b1, st: HS_IDLE, scl_oe_n: 1'b1,
                                    sda_oe_n: 1'b1, default: '0};

  ics_hstate_t s;
  ics_hstate_t n;

  // Released (1) or driven low (0) level for bit i of a byte slot
  function automatic logic hbit(input logic rdop, input logic ackv, input logic [7:0] tx,
                                input logic [3:0] i);
    if (i == BYTE_BITS) hbit = rdop ? ~ackv : 1'b1;
    else hbit = rdop ? 1'b1 : tx[3'h7 - i[2:0]];
  endfunction

  always_comb begin
    logic acc;
    acc = psel & penable & ~s.pready;
    n = s;
    n.sda_s = {s.sda_s[1:0], bus.sda};
    if (s.sda_s[1] == s.sda_s[2]) n.sda_f = s.sda_s[2];
    n.pready = acc;
    if (acc) begin
      case (paddr)
        HREG_DATA: n.prdata = {24'h0, s.rx};
        HREG_STAT: n.prdata = {30'h0, s.nack, s.st != HS_IDLE};
        default:   n.prdata = '0;
      endcase
    end
    if (s.st != HS_IDLE) begin
      if (s.qcnt == QTR_LAST) begin
        n.qcnt = '0;
        n.ph = s.ph + 2'h1;
        case (s.ph)
          2'h0: n.scl_oe_n = 1'b1;
          2'h1: begin
            if (s.st == HS_START) n.sda_oe_n = 1'b0;
            else if (s.st == HS_STOP) n.sda_oe_n = 1'b1;
            else if (s.bitn != BYTE_BITS) n.rx = {s.rx[6:0], s.sda_f};
            else if (!s.rdop) n.nack = s.sda_f;
          end
          2'h2: if (s.st != HS_STOP) n.scl_oe_n = 1'b0;
          default: begin
            if (s.st == HS_BIT && s.bitn != BYTE_BITS) begin
              n.bitn = s.bitn + 4'h1;
              n.sda_oe_n = hbit(s.rdop, s.ackv, s.tx, n.bitn);
            end else begin
              n.st = HS_IDLE;
            end
          end
        endcase
      end else begin
        n.qcnt = s.qcnt + {{(QTR_W-1){1'b0}}, 1'b1};
      end
    end
    if (psel && penable && s.pready && pwrite) begin
      if (paddr == HREG_DATA) n.tx = pwdata[7:0];
      // Commands while busy are ignored; software polls the busy bit
      if (paddr == HREG_CMD && s.st == HS_IDLE) begin
        n.qcnt = '0;
        n.ph = '0;
        n.bitn = '0;
        n.scl_oe_n = 1'b0;
        case (ics_op_t'(pwdata[1:0]))
          OP_START: begin
            n.st = HS_START;
            n.sda_oe_n = 1'b1;
          end
          OP_STOP: begin
            n.st = HS_STOP;
            n.sda_oe_n = 1'b0;
          end
          default: begin
            n.st = HS_BIT;
            n.nack = 1'b0;
            n.rdop = (pwdata[1:0] == OP_READ);
            n.ackv = pwdata[CMD_ACK_BIT];
            n.sda_oe_n = hbit(n.rdop, n.ackv, n.tx, '0);
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= H_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = 1'b0;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe_n = s.scl_oe_n;
  assign bus.host_sda_oe_n = s.sda_oe_n;

endmodule
`default_nettype wire

/* tb/ics_link_checker.sv */
/*
  Concurrent checks on the two-wire link between host end and device end.
  Assumes one pclk domain and open-drain pins with active-low enables.
*/
`timescale 1ns/1ps
`default_nettype none
module ics_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  a_dev_open_drain: assert property (dev_sda_o == 1'b0)
    else $error("device data pin drives a high level");
  a_host_open_drain: assert property (host_scl_o == 1'b0 && host_sda_o == 1'b0)
    else $error("host pin drives a high level");
  a_dev_grab_low: assert property ($fell(dev_sda_oe_n) |-> !scl)
    else $error("device took data line while clock high");
  a_dev_free_low: assert property ($rose(dev_sda_oe_n) |-> !scl)
    else $error("device released data line while clock high");
  // Acknowledge must not move while the host samples it
  a_ack_held_high: assert property ($rose(scl) && !dev_sda_oe_n |=> !dev_sda_oe_n [*8])
    else $error("device dropped acknowledge during clock high");
  a_start_then_low: assert property (s_start |-> ##[1:320] !scl)
    else $error("clock not lowered after start");
  a_stop_idle: assert property (s_stop |=> (scl && sda) [*8])
    else $error("bus not idle after stop");
  a_stop_dev_free: assert property (s_stop |-> dev_sda_oe_n)
    else $error("device holds data line at stop");
  a_scl_high_span: assert property ($rose(scl) |=> scl [*8])
    else $error("clock high phase too short");
endmodule
`default_nettype wire

/* tb/i2c_slave_command_port_bench.sv */
/*
  Self-checking bench: host end driven over APB, device end on the same link,
  requests collected at the device's user side.
  Assumes one APB wait state and byte ops of 36 quarters of 79 pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_command_port_bench
  import ics_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        req_valid;
  logic        req_ready;
  ics_req_t    req;
  logic [31:0] rd_data;
  logic [31:0] r;
  ics_req_t    got_q[$];
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [7:0]  dw [5] = '{8'h40, 8'h60, 8'hfc, 8'hcd, 8'hab};
  logic [7:0]  ra [3] = '{8'h44, 8'h53, 8'h10};

  ics_if link ();
  ics_host_end ics_host_end_i (.pclk(pclk), .presetn(presetn), .bus(link), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  ics_dev_end ics_dev_end_i (.pclk(pclk), .presetn(presetn), .bus(link),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_data(rd_data));
  ics_link_checker ics_link_checker_i (.pclk(pclk), .presetn(presetn), .scl(link.scl),
    .sda(link.sda), .host_scl_o(link.host_scl_o), .host_scl_oe_n(link.host_scl_oe_n),
    .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n));

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    if (req_valid === 1'b1 && req_ready === 1'b1) begin
      got_q.push_back(req);
    end
  end

  task automatic check(input string what, input logic [69:0] seen, input logic [69:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("Checked %0d values, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One edge first, so a release and a new setup never share a time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic hop(input logic [1:0] op);
    logic [31:0] s;
    apb(1'b1, HREG_CMD, {30'h0, op}, s);
    s = 32'h1;
    while (s[STAT_BUSY] !== 1'b0) apb(1'b0, HREG_STAT, 32'h0, s);
  endtask

  task automatic send(input logic [7:0] b, input logic nack_exp);
    logic [31:0] s;
    apb(1'b1, HREG_DATA, {24'h0, b}, s);
    hop(OP_WRITE);
    apb(1'b0, HREG_STAT, 32'h0, s);
    check("nack", {69'h0, s[STAT_NACK]}, {69'h0, nack_exp});
  endtask

  task automatic expect_req(input ics_req_t e);
    ics_req_t g;
    g = 'x;
    if (got_q.size() > 0) g = got_q.pop_front();
    check("req", 70'(g), 70'(e));
  endtask

  initial begin
    repeat (99000) @(posedge pclk);
    mismatches++;
    $display("Error watchdog expected done seen timeout");
    wrap_up();
  end

  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    req_ready = 1'b0;
    rd_data   = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h0ff, 32'h0, r);
    check("unmapped", {38'h0, r}, 70'h0);
    check("slverr", {69'h0, pslverr}, 70'h0);
    // Two sequences in one frame while the receiver stalls
    hop(OP_START);
    send(DEV_ADDR_W, 1'b0);
    send(REG_WRITE1_CMD, 1'b0);
    send(8'h05, 1'b0);
    send(8'ha5, 1'b0);
    send(DATA_MEM_WRITE_CMD, 1'b0);
    for (int i = 0; i < 5; i++) send(dw[i], 1'b0);
    hop(OP_STOP);
    check("held", {69'h0, req_valid}, 70'h1);
    req_ready <= 1'b1;
    for (int i = 0; i < 20 && got_q.size() < 2; i++) @(posedge pclk);
    expect_req('{TGT_REG, 1'b1, 24'h000005, 32'h000000a5, 3'h1});
    expect_req('{TGT_DATA, 1'b1, 24'hfc6040, 32'h0000abcd, 3'h2});
    hop(OP_START);
    send(8'he4, 1'b1);
    hop(OP_STOP);
    hop(OP_START);
    send(DEV_ADDR_W, 1'b0);
    send(8'h68, 1'b1);
    hop(OP_STOP);
    // Stop cuts a two-byte register write short
    hop(OP_START);
    send(DEV_ADDR_W, 1'b0);
    send(REG_WRITE2_CMD, 1'b0);
    send(8'h06, 1'b0);
    send(8'h11, 1'b0);
    hop(OP_STOP);
    hop(OP_START);
    send(DEV_ADDR_W, 1'b0);
    send(INSTR_MEM_READ_CMD, 1'b0);
    for (int i = 0; i < 3; i++) send(ra[i], 1'b0);
    // Byte counter of one, then a data-only write in the same frame
    send(REG_WRITE1_CMD, 1'b0);
    send(BCNT_REG_ADDR[7:0], 1'b0);
    send(8'h01, 1'b0);
    send(8'ha8, 1'b0);
    send(8'h5a, 1'b0);
    hop(OP_STOP);
    for (int i = 0; i < 20 && got_q.size() < 3; i++) @(posedge pclk);
    check("count", 70'(got_q.size()), 70'h3);
    expect_req('{TGT_INSTR, 1'b0, 24'h105344, 32'h0, 3'h0});
    expect_req('{TGT_REG, 1'b1, 24'h000008, 32'h00000001, 3'h1});
    expect_req('{TGT_DATA, 1'b1, 24'h000000, 32'h0000005a, 3'h1});
    wrap_up();
  end
endmodule
`default_nettype wire
